// ### tb/mac_source.sv
// Behavioural receive MAC that feeds frames into the ring manager.
// Assumes it shares clk_sys with the design and is driven from bench tasks.
`timescale 1ns/1ps
`default_nettype none

module mac_source
    import rx_ring_pkg::*;
(
    input  wire logic   clk_sys,
    output var  rx_in_t rx_in
);
    initial rx_in = '0;

    // Sends optional start, n bytes and optional done with error flags, one per cycle.
    // Idle data shows the inverse of the last byte, so a late sample is caught.
    task automatic send(input int n, input logic crc, input logic runt,
                        input logic st, input logic fin);
        if (st) begin
            rx_in.start <= 1'b1;
            @(posedge clk_sys);
            rx_in.start <= 1'b0;
        end
        for (int i = 0; i < n; i++) begin
            rx_in.valid <= 1'b1;
            rx_in.data  <= i[7:0];
            @(posedge clk_sys);
        end
        rx_in.valid <= 1'b0;
        rx_in.data  <= ~rx_in.data;
        if (fin) begin
            rx_in.done    <= 1'b1;
            rx_in.crc_err <= crc;
            rx_in.runt    <= runt;
            @(posedge clk_sys);
            rx_in.done    <= 1'b0;
            rx_in.crc_err <= 1'b0;
            rx_in.runt    <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ### tb/test_rx_ring_early_int_manager.sv
// Self-checking bench for the receive ring manager over APB.
// Assumes the MAC partner in mac_source and a 200 MHz clk_sys.
`timescale 1ns/1ps
`default_nettype none

module test_rx_ring_early_int_manager;
    import rx_ring_pkg::*;

    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rx_busy, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] tx_local_addr, tx_remote_addr, first_addr;
    logic        tx_remote_active, err;
    logic [7:0]  v;
    logic [7:0]  hdr [4];
    rx_in_t      rx_in;
    mem_wr_t     mem_wr;
    int          error_cnt, total_checks, cycles;

    rx_ring_manager u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .tx_local_addr(tx_local_addr),
        .tx_remote_addr(tx_remote_addr), .tx_remote_active(tx_remote_active),
        .mem_wr(mem_wr), .rx_busy(rx_busy), .irq(irq));
    mac_source u_mac (.clk_sys(clk_sys), .rx_in(rx_in));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Header bytes and the first data byte address are captured as written.
    always @(posedge clk_sys) begin
        if (mem_wr.en === 1'b1 && mem_wr.addr[7:0] < 8'h04) hdr[mem_wr.addr[1:0]] <= mem_wr.data;
        if (mem_wr.en === 1'b1 && mem_wr.addr[7:0] == 8'h04) first_addr <= mem_wr.addr;
    end

    // A hung handshake must not stall the run, so a cycle ceiling ends it.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        apb(1'b1, idx, wd, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] m,
                       input logic [7:0] exp);
        logic [7:0] d;
        apb(1'b0, idx, 8'h00, d);
        chk(nm, exp, d & m);
    endtask

    // Whole frame, then wait until the sequencer is idle again.
    task automatic frame(input int n, input logic crc, input logic runt);
        u_mac.send(n, crc, runt, 1'b1, 1'b1);
        while (rx_busy !== 1'b0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic note(input string nm);
        $display("test %s done", nm);
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, tx_remote_active} = '0;
        {paddr, pwdata, tx_local_addr, tx_remote_addr} = '0;
        {error_cnt, total_checks, cycles} = '0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc("ring_start", IDX_RING_START, 8'hff, 8'h46);
        rdc("ring_stop", IDX_RING_STOP, 8'hff, 8'h80);
        rdc("current_write_page", IDX_CURRENT_PAGE, 8'hff, 8'h46);
        rdc("boundary_page", IDX_BOUNDARY, 8'hff, 8'h46);
        apb(1'b0, 8'h30, 8'h00, v);
        chk("unmapped_slverr", 8'h01, {7'h0, err});
        note("reset");
        frame(10, 1'b0, 1'b0);
        chk("first_page", 8'h46, first_addr[15:8]);
        chk("first_offset", 8'h04, first_addr[7:0]);
        chk("hdr_status", 8'h01, hdr[0] & 8'h01);
        chk("hdr_next", 8'h47, hdr[1]);
        chk("hdr_count", 8'h0a, hdr[2]);
        rdc("current_good", IDX_CURRENT_PAGE, 8'hff, 8'h47);
        rdc("isr_good", IDX_INT_STATUS, 8'h05, 8'h01);
        rdc("rsr_good", IDX_RX_STATUS, 8'h01, 8'h01);
        wr(IDX_INT_STATUS, 8'hff);
        note("good");
        frame(20, 1'b1, 1'b0);
        rdc("current_crc", IDX_CURRENT_PAGE, 8'hff, 8'h47);
        rdc("isr_crc", IDX_INT_STATUS, 8'h04, 8'h04);
        wr(IDX_RX_CONFIG, 8'h01);
        frame(20, 1'b1, 1'b0);
        rdc("current_saved", IDX_CURRENT_PAGE, 8'hff, 8'h48);
        wr(IDX_RX_CONFIG, 8'h00);
        frame(8, 1'b0, 1'b1);
        rdc("current_runt", IDX_CURRENT_PAGE, 8'hff, 8'h48);
        wr(IDX_TX_CONFIG, 8'h01);
        frame(8, 1'b0, 1'b1);
        rdc("current_runt_ok", IDX_CURRENT_PAGE, 8'hff, 8'h49);
        wr(IDX_TX_CONFIG, 8'h00);
        note("overwrite");
        wr(IDX_BOUNDARY, 8'h4a);
        frame(10, 1'b0, 1'b0);
        rdc("current_full", IDX_CURRENT_PAGE, 8'hff, 8'h49);
        rdc("tally_full", IDX_MISSED_TALLY, 8'hff, 8'h01);
        rdc("rsr_missed", IDX_RX_STATUS, 8'h10, 8'h10);
        wr(IDX_BOUNDARY, 8'h46);
        frame(10, 1'b0, 1'b0);
        rdc("current_resume", IDX_CURRENT_PAGE, 8'hff, 8'h4a);
        note("ring_full");
        // One-page ring tail with the boundary outside the ring forces a wrap.
        wr(IDX_RING_STOP, 8'h4b);
        wr(IDX_BOUNDARY, 8'h10);
        frame(300, 1'b0, 1'b0);
        rdc("current_wrap", IDX_CURRENT_PAGE, 8'hff, 8'h47);
        chk("hdr_next_wrap", 8'h47, hdr[1]);
        chk("hdr_count_hi", 8'h01, hdr[3]);
        note("wrap");
        wr(IDX_RING_STOP, 8'h80);
        wr(IDX_BOUNDARY, 8'h46);
        wr(IDX_DIAG, 8'h08);
        wr(IDX_INT_STATUS, 8'hff);
        u_mac.send(66, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk_sys);
        rdc("isr_early", IDX_INT_STATUS, 8'h01, 8'h01);
        rdc("rsr_early", IDX_RX_STATUS, 8'h01, 8'h00);
        rdc("count_low", IDX_BYTE_COUNT_LOW, 8'hff, 8'h42);
        rdc("count_high", IDX_BYTE_COUNT_HIGH, 8'hff, 8'h00);
        rdc("current_early", IDX_CURRENT_PAGE, 8'hff, 8'h47);
        // Host view: the packet starts on the page after the boundary, wrapped at ring stop.
        apb(1'b0, IDX_BOUNDARY, 8'h00, v);
        v = v + 8'h01;
        if (v >= 8'h80) v = v - (8'h80 - 8'h46);
        chk("remote_start_page", v, first_addr[15:8]);
        // Only done is sent: a second start while busy breaks the stream order.
        u_mac.send(0, 1'b0, 1'b0, 1'b0, 1'b1);
        while (rx_busy !== 1'b0) @(posedge clk_sys);
        rdc("rsr_early_done", IDX_RX_STATUS, 8'h01, 8'h01);
        // Page interrupt: clear after the header flag, then cross a page boundary.
        u_mac.send(100, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(IDX_INT_STATUS, 8'hff);
        u_mac.send(160, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (2) @(posedge clk_sys);
        rdc("isr_page", IDX_INT_STATUS, 8'h01, 8'h01);
        rdc("rsr_page", IDX_RX_STATUS, 8'h01, 8'h00);
        rdc("count_high_page", IDX_BYTE_COUNT_HIGH, 8'hff, 8'h01);
        u_mac.send(0, 1'b0, 1'b0, 1'b0, 1'b1);
        while (rx_busy !== 1'b0) @(posedge clk_sys);
        rdc("current_page_done", IDX_CURRENT_PAGE, 8'hff, 8'h4a);
        note("early_rx");
        wr(IDX_CONFIG_B, 8'h01);
        wr(IDX_INT_MASK, 8'h08);
        tx_local_addr    <= 16'h0200;
        tx_remote_addr   <= 16'h0100;
        tx_remote_active <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("irq_tx", 8'h01, {7'h0, irq});
        rdc("tsr_under", IDX_TX_STATUS, 8'h20, 8'h20);
        rdc("isr_tx", IDX_INT_STATUS, 8'h08, 8'h08);
        note("early_tx");
        finish_test();
    end
endmodule

`default_nettype wire

// ### verilog/rx_ring_manager.sv
// Receive ring manager with early receive and early transmit error checks.
// Assumes an APB master on clk_sys and a MAC byte stream on the same clock.
`timescale 1ns/1ps
`default_nettype none

module rx_ring_manager (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire rx_ring_pkg::rx_in_t   rx_in,
    input  wire logic [15:0]           tx_local_addr,
    input  wire logic [15:0]           tx_remote_addr,
    input  wire logic                  tx_remote_active,
    output var rx_ring_pkg::mem_wr_t   mem_wr,
    output logic                       rx_busy,
    output logic                       irq
);
    import rx_ring_pkg::*;

    state_t     st;
    state_t     next_st;
    logic [7:0] adv_page;
    logic       bnd_in_ring;
    logic       ring_full;
    logic [7:0] reg_idx;
    logic       early_mode;

    // Ring geometry helpers; the boundary only protects data while it sits inside the ring.
    always_comb begin
        adv_page    = (st.wr_page + 8'h01 == st.ring_stop) ? st.ring_start
                                                           : st.wr_page + 8'h01;
        bnd_in_ring = (st.boundary >= st.ring_start) && (st.boundary < st.ring_stop);
        ring_full   = bnd_in_ring && (adv_page == st.boundary);
        reg_idx     = paddr[9:2];
        early_mode  = st.diag[DIAG_EARLY_RX];
    end

    // Next-state logic: bus access first, then hardware events so that a set wins a clear.
    always_comb begin
        next_st         = st;
        next_st.mem.en  = 1'b0;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;

        // Read data and the error answer are prepared in the first access cycle.
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            case (reg_idx)
                IDX_BYTE_COUNT_LOW:  next_st.prdata[7:0] = st.count[7:0];
                IDX_BYTE_COUNT_HIGH: next_st.prdata[7:0] = st.count[15:8];
                IDX_INT_STATUS:      next_st.prdata[7:0] = st.interrupt_status;
                IDX_RX_STATUS:       next_st.prdata[7:0] = st.receive_status;
                IDX_RING_START:      next_st.prdata[7:0] = st.ring_start;
                IDX_RING_STOP:       next_st.prdata[7:0] = st.ring_stop;
                IDX_BOUNDARY:        next_st.prdata[7:0] = st.boundary;
                IDX_TX_STATUS:       next_st.prdata[7:0] = st.transmit_status_reg;
                IDX_CURRENT_PAGE:    next_st.prdata[7:0] = st.current;
                IDX_MISSED_TALLY:    next_st.prdata[7:0] = st.tally;
                IDX_INT_MASK:        next_st.prdata[7:0] = st.imr;
                IDX_RX_CONFIG:       next_st.prdata[7:0] = st.rx_cfg;
                IDX_TX_CONFIG:       next_st.prdata[7:0] = st.tx_cfg;
                IDX_DIAG:            next_st.prdata[7:0] = st.diag;
                IDX_CONFIG_B:        next_st.prdata[7:0] = st.cfg_b;
                default:             next_st.pslverr = 1'b1;
            endcase
        end

        // Writes land at the edge where pready is seen high.
        if (psel && penable && st.pready && pwrite) begin
            case (reg_idx)
                IDX_INT_STATUS:   next_st.interrupt_status = st.interrupt_status & ~pwdata[7:0];
                IDX_BOUNDARY:     next_st.boundary = pwdata[7:0];
                IDX_INT_MASK:     next_st.imr = pwdata[7:0];
                IDX_RX_CONFIG:    next_st.rx_cfg = pwdata[7:0];
                IDX_TX_CONFIG:    next_st.tx_cfg = pwdata[7:0];
                IDX_DIAG:         next_st.diag = pwdata[7:0];
                IDX_CONFIG_B:     next_st.cfg_b = pwdata[7:0];
                IDX_TX_STATUS:    next_st.transmit_status_reg = st.transmit_status_reg & ~pwdata[7:0];
                IDX_MISSED_TALLY: next_st.tally = 8'h00;
                IDX_CURRENT_PAGE: begin
                    if (st.fsm == S_IDLE) begin
                        next_st.current = pwdata[7:0];
                    end
                end
                IDX_RING_START: begin
                    if (st.fsm == S_IDLE) begin
                        next_st.ring_start = pwdata[7:0];
                    end
                end
                IDX_RING_STOP: begin
                    if (st.fsm == S_IDLE) begin
                        next_st.ring_stop = pwdata[7:0];
                    end
                end
                default: next_st.pslverr = 1'b0;
            endcase
        end

        // Receive sequencer; the write page walks the ring, current only moves on completion.
        case (st.fsm)
            S_IDLE: begin
                if (rx_in.start) begin
                    next_st.fsm          = S_RECV;
                    next_st.wr_page      = st.current;
                    next_st.offset       = HEADER_BYTES;
                    next_st.count        = 16'h0000;
                    next_st.receive_status[RSR_PKT_RX] = 1'b0;
                end
            end
            S_RECV: begin
                if (rx_in.valid) begin
                    next_st.mem.en   = 1'b1;
                    next_st.mem.addr = {st.wr_page, st.offset};
                    next_st.mem.data = rx_in.data;
                    next_st.count    = st.count + 16'h0001;
                    next_st.offset   = st.offset + 8'h01;
                    if (early_mode && st.count == EARLY_HDR_COUNT) begin
                        next_st.interrupt_status[INT_PKT_RX] = 1'b1;
                    end
                    if (st.offset == LAST_PAGE_BYTE) begin
                        if (ring_full) begin
                            // No room: drop the rest rather than overrun unread packets.
                            next_st.fsm                = S_DROP;
                            next_st.tally              = st.tally + 8'h01;
                            next_st.receive_status[RSR_MISSED]    = 1'b1;
                            next_st.interrupt_status[INT_OVERWRITE] = 1'b1;
                        end else begin
                            next_st.wr_page = adv_page;
                            if (early_mode) begin
                                next_st.interrupt_status[INT_PKT_RX] = 1'b1;
                            end
                        end
                    end
                end else if (rx_in.done) begin
                    next_st.receive_status[RSR_CRC_ERR]   = rx_in.crc_err;
                    next_st.receive_status[RSR_ALIGN_ERR] = rx_in.align_err;
                    if (((rx_in.crc_err || rx_in.align_err) && !st.rx_cfg[RCR_SAVE_ERR]) ||
                        (rx_in.runt && !st.tx_cfg[TCR_RUNT_ACCEPT])) begin
                        // Current is left alone so the next packet lands on top of this one.
                        next_st.fsm              = S_IDLE;
                        next_st.interrupt_status[INT_RX_ERR]  = 1'b1;
                        next_st.count            = 16'h0000;
                    end else if (ring_full) begin
                        next_st.fsm                = S_IDLE;
                        next_st.tally              = st.tally + 8'h01;
                        next_st.receive_status[RSR_MISSED]    = 1'b1;
                        next_st.interrupt_status[INT_OVERWRITE] = 1'b1;
                        next_st.count              = 16'h0000;
                    end else begin
                        next_st.fsm      = S_HDR;
                        next_st.hdr_idx  = 2'd0;
                        next_st.next_pkt = adv_page;
                        if (rx_in.crc_err || rx_in.align_err) begin
                            next_st.interrupt_status[INT_RX_ERR] = 1'b1;
                        end
                    end
                end
            end
            S_DROP: begin
                if (rx_in.done) begin
                    next_st.fsm   = S_IDLE;
                    next_st.count = 16'h0000;
                end
            end
            S_HDR: begin
                // Header bytes: status, next packet page, count low, count high.
                next_st.mem.en   = 1'b1;
                next_st.mem.addr = {st.current, 6'h00, st.hdr_idx};
                case (st.hdr_idx)
                    2'd0:    next_st.mem.data = st.receive_status | 8'h01;
                    2'd1:    next_st.mem.data = st.next_pkt;
                    2'd2:    next_st.mem.data = st.count[7:0];
                    default: next_st.mem.data = st.count[15:8];
                endcase
                next_st.hdr_idx = st.hdr_idx + 2'd1;
                if (st.hdr_idx == 2'd3) begin
                    next_st.fsm             = S_IDLE;
                    next_st.current         = st.next_pkt;
                    next_st.count           = 16'h0000;
                    next_st.interrupt_status[INT_PKT_RX] = 1'b1;
                    next_st.receive_status[RSR_PKT_RX] = 1'b1;
                end
            end
            default: next_st.fsm = S_IDLE;
        endcase

        // Local read pointer overtaking the remote fill pointer means a corrupt send.
        if (st.cfg_b[CFGB_EARLY_TX] && tx_remote_active && (tx_local_addr > tx_remote_addr)) begin
            next_st.transmit_status_reg[TSR_EARLY_UNDER] = 1'b1;
            next_st.interrupt_status[INT_TX_ERR]      = 1'b1;
        end

        next_st.irq  = |(next_st.interrupt_status & st.imr);
        next_st.busy = (next_st.fsm != S_IDLE);
    end

    // All state lives in one register; outputs come straight from it.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st            <= '0;
            st.fsm        <= S_IDLE;
            st.ring_start <= RST_RING_START;
            st.ring_stop  <= RST_RING_STOP;
            st.current    <= RST_RING_START;
            st.boundary   <= RST_RING_START;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign mem_wr  = st.mem;
    assign rx_busy = st.busy;
    assign irq     = st.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    ring_lock_a: assert property ((st.fsm != S_IDLE) |=> $stable(st.ring_start) && $stable(st.ring_stop))
        else $error("Ring limits moved during reception.");

    data_offset_a: assert property ((st.fsm == S_IDLE && rx_in.start) |=> st.offset == 8'h04)
        else $error("Packet data does not start four bytes in.");

    page_wrap_a: assert property ((st.fsm == S_RECV && rx_in.valid && st.offset == 8'hff && !ring_full)
        |=> st.wr_page == $past(adv_page) && st.offset == 8'h00)
        else $error("Write page did not advance or wrap correctly.");

    header_write_a: assert property ($rose(st.fsm == S_HDR) |=> st.mem.en [*4] ##1 st.fsm == S_IDLE)
        else $error("Header not written as four bytes.");

    error_keep_a: assert property ((st.fsm == S_RECV && !rx_in.valid && rx_in.done && rx_in.crc_err
        && !st.rx_cfg[RCR_SAVE_ERR]) |=> $stable(st.current) && st.interrupt_status[INT_RX_ERR])
        else $error("Errored packet moved the current page.");

    runt_keep_a: assert property ((st.fsm == S_RECV && !rx_in.valid && rx_in.done && rx_in.runt
        && !st.tx_cfg[TCR_RUNT_ACCEPT]) |=> st.fsm == S_IDLE && $stable(st.current))
        else $error("Runt packet was kept.");

    full_abort_a: assert property ((st.fsm == S_RECV && rx_in.valid && st.offset == 8'hff && ring_full)
        |=> st.fsm == S_DROP && st.tally == $past(st.tally) + 8'h01)
        else $error("Full ring did not abort and count the packet.");

    early_header_a: assert property ((st.fsm == S_RECV && rx_in.valid && early_mode
        && st.count == 16'h0040) |=> st.interrupt_status[INT_PKT_RX] && !st.receive_status[RSR_PKT_RX])
        else $error("Early header flag missing.");

    early_page_a: assert property ((st.fsm == S_RECV && rx_in.valid && early_mode
        && st.offset == 8'hff && !ring_full) |=> st.interrupt_status[INT_PKT_RX])
        else $error("Early page flag missing.");

    byte_count_a: assert property ((st.fsm == S_RECV && rx_in.valid)
        |=> st.count == $past(st.count) + 16'h0001)
        else $error("Byte counter did not follow received bytes.");

    early_tx_a: assert property ((st.cfg_b[CFGB_EARLY_TX] && tx_remote_active
        && tx_local_addr > tx_remote_addr) |=> st.transmit_status_reg[5] && st.interrupt_status[3])
        else $error("Early transmit error not flagged.");

endmodule

`default_nettype wire

// ### verilog/rx_ring_pkg.sv
// Package for the receive ring manager: register indices, field positions,
// reset values, carrier structs and the controller state type.
// Assumes APB byte addresses are four times the register index.
package rx_ring_pkg;

    // Register indices; byte address is index times four.
    localparam logic [7:0] IDX_BYTE_COUNT_LOW  = 8'h01;
    localparam logic [7:0] IDX_BYTE_COUNT_HIGH = 8'h02;
    localparam logic [7:0] IDX_INT_STATUS      = 8'h07;
    localparam logic [7:0] IDX_RX_STATUS       = 8'h0c;
    localparam logic [7:0] IDX_RING_START      = 8'h11;
    localparam logic [7:0] IDX_RING_STOP       = 8'h12;
    localparam logic [7:0] IDX_BOUNDARY        = 8'h13;
    localparam logic [7:0] IDX_TX_STATUS       = 8'h14;
    localparam logic [7:0] IDX_CURRENT_PAGE    = 8'h17;
    localparam logic [7:0] IDX_MISSED_TALLY    = 8'h1a;
    localparam logic [7:0] IDX_INT_MASK        = 8'h1b;
    localparam logic [7:0] IDX_RX_CONFIG       = 8'h1c;
    localparam logic [7:0] IDX_TX_CONFIG       = 8'h1d;
    localparam logic [7:0] IDX_DIAG            = 8'h1e;
    localparam logic [7:0] IDX_CONFIG_B        = 8'h1f;

    // Field positions.
    localparam int INT_PKT_RX      = 0;
    localparam int INT_RX_ERR      = 2;
    localparam int INT_TX_ERR      = 3;
    localparam int INT_OVERWRITE   = 4;
    localparam int RSR_PKT_RX      = 0;
    localparam int RSR_CRC_ERR     = 1;
    localparam int RSR_ALIGN_ERR   = 2;
    localparam int RSR_MISSED      = 4;
    localparam int TSR_EARLY_UNDER = 5;
    localparam int RCR_SAVE_ERR    = 0;
    localparam int TCR_RUNT_ACCEPT = 0;
    localparam int DIAG_EARLY_RX   = 3;
    localparam int CFGB_EARLY_TX   = 0;

    // Reset values and packet layout constants.
    localparam logic [7:0]  RST_RING_START  = 8'h46;
    localparam logic [7:0]  RST_RING_STOP   = 8'h80;
    localparam logic [7:0]  HEADER_BYTES    = 8'h04;
    localparam logic [7:0]  LAST_PAGE_BYTE  = 8'hff;
    localparam logic [15:0] EARLY_HDR_COUNT = 16'h0040;

    // Receive stream from the MAC, same clock.
    typedef struct packed {
        logic       start;
        logic       valid;
        logic [7:0] data;
        logic       done;
        logic       crc_err;
        logic       align_err;
        logic       runt;
    } rx_in_t;

    // Byte write into packet memory.
    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_t;

    typedef enum logic [1:0] {S_IDLE, S_RECV, S_DROP, S_HDR} rx_state_t;

    typedef struct packed {
        rx_state_t   fsm;
        logic [7:0]  ring_start;
        logic [7:0]  ring_stop;
        logic [7:0]  current;
        logic [7:0]  boundary;
        logic [7:0]  rx_cfg;
        logic [7:0]  tx_cfg;
        logic [7:0]  diag;
        logic [7:0]  cfg_b;
        logic [7:0]  imr;
        logic [7:0]  interrupt_status;
        logic [7:0]  receive_status;
        logic [7:0]  transmit_status_reg;
        logic [7:0]  tally;
        logic [7:0]  wr_page;
        logic [7:0]  offset;
        logic [15:0] count;
        logic [1:0]  hdr_idx;
        logic [7:0]  next_pkt;
        mem_wr_t     mem;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic        busy;
    } state_t;

endpackage
